/* File: dv/ppb_bridge_assertions.sv */
// Purpose: port checks for the programming port bus bridge
// Assumes: cpu_stopped held high through every drive phase
// Notes:   bound into every ppb_bridge instance
`timescale 1ns/10ps
module ppb_bridge_assertions
    import ppb_pkg::*;
#(
    parameter int STROBE_CYC = 1
) (
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    input wire logic                  cpu_stopped,
    input wire logic [PPB_ADDR_W-1:0] prog_mem_addr,
    input wire logic                  prog_mem_addr_oe,
    input wire logic                  addr_bus_enable_n,
    input wire logic                  update_phase,
    input wire logic                  prog_mem_write,
    input wire logic                  scratch_data_oe,
    input wire logic                  scratch_write_en_n,
    input wire logic                  stop_request,
    input wire logic                  link_ready,
    input wire logic                  system_stop_en_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_drive_start; $rose(update_phase); endsequence
    sequence s_strobe_start; $rose(prog_mem_write); endsequence
    property p_addr_drive;
        prog_mem_addr_oe |-> !addr_bus_enable_n && update_phase;
    endproperty
    property p_addr_rel; !prog_mem_addr_oe |-> prog_mem_addr == '0; endproperty
    property p_write_drive;
        prog_mem_write |-> prog_mem_addr_oe && !addr_bus_enable_n;
    endproperty
    // strobe spans at least four core_clk cycles of 8 ns, 32 ns
    property p_strobe_hold; s_strobe_start |-> prog_mem_write [*4]; endproperty
    property p_sp_dir;
        !scratch_write_en_n |-> scratch_data_oe && update_phase;
    endproperty
    property p_stop_first; s_drive_start |-> cpu_stopped; endproperty
    property p_ready_off; update_phase |-> !link_ready; endproperty
    // enable output is registered one cycle behind the stop request
    property p_sse; !system_stop_en_n |-> $past(stop_request); endproperty
    a_addr_drive: assert property (p_addr_drive)
        else $error("address bus driven outside update phase");
    a_addr_rel: assert property (p_addr_rel)
        else $error("released address bus not at zero");
    a_write_drive: assert property (p_write_drive)
        else $error("program write strobe without address drive");
    a_strobe_hold: assert property (p_strobe_hold)
        else $error("program write strobe too short");
    a_sp_dir: assert property (p_sp_dir)
        else $error("scratch write without scratch bus drive");
    a_stop_first: assert property (p_stop_first)
        else $error("drive began with processor running");
    a_ready_off: assert property (p_ready_off)
        else $error("ready high during drive phase");
    a_sse: assert property (p_sse)
        else $error("system stop enable without stop request");
endmodule : ppb_bridge_assertions

bind ppb_bridge ppb_bridge_assertions #(.STROBE_CYC(STROBE_CYC)) chk_u (
    .core_clk, .reset_n, .cpu_stopped, .prog_mem_addr, .prog_mem_addr_oe,
    .addr_bus_enable_n, .update_phase, .prog_mem_write, .scratch_data_oe,
    .scratch_write_en_n, .stop_request, .link_ready, .system_stop_en_n);

/* File: dv/ppb_bridge_bench.sv */
// Purpose: self-checking bench for the programming port bus bridge
// Assumes: processor side modelled inline, programming unit by model
// Notes:   strobe count shortened to one cpu clock edge
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module ppb_bridge_bench;
    import ppb_pkg::*;
    logic                   core_clk, reset_n, cpu_clock, cpu_stopped;
    logic [PPB_PDATA_W-1:0] prog_data_in;
    logic [4:0]             instr_in;
    logic [PPB_ADDR_W-1:0]  prog_mem_addr, pm_seen;
    logic                   prog_mem_addr_oe, addr_bus_enable_n;
    logic                   update_phase, prog_mem_write, scratch_data_oe;
    logic [PPB_SDATA_W-1:0] scratch_data_out, scratch_data_in, sp_val, sp_seen;
    logic                   scratch_write_en_n, stop_request, link_clock_n;
    logic                   link_data_in_n, link_data_out, transfer_req_n;
    logic                   link_ready, system_stop_en_n, code_error;
    logic [10:0]            rep;
    int                     n_fail, n_checks, cyc, drv;
    // two-way scratch bus: device drives only while enabled
    assign scratch_data_in = scratch_data_oe ? scratch_data_out : sp_val;
    ppb_bridge #(.STROBE_CYC(1)) dut_u (.core_clk, .reset_n, .cpu_clock,
        .cpu_stopped, .prog_data_in, .instr_in, .prog_mem_addr,
        .prog_mem_addr_oe, .addr_bus_enable_n, .update_phase,
        .prog_mem_write, .scratch_data_out, .scratch_data_oe,
        .scratch_data_in, .scratch_write_en_n, .stop_request, .link_clock_n,
        .link_data_in_n, .link_data_out, .transfer_req_n, .link_ready,
        .system_stop_en_n, .code_error);
    ppb_link_model pu_u (.link_clock_n, .link_data_in_n, .transfer_req_n,
        .link_data_out, .link_ready);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        cpu_clock = 1'b0;
        forever #23 cpu_clock = ~cpu_clock;
    end
    always @(posedge core_clk) begin
        if (prog_mem_write === 1'b1) pm_seen <= prog_mem_addr;
        if (scratch_write_en_n === 1'b0) sp_seen <= scratch_data_out;
        if (update_phase === 1'b1) drv <= drv + 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            results();
        end
    end
    function automatic logic [31:0] mk(input logic [3:0] c, input bit bad,
        input logic [12:0] a, input logic [10:0] d);
        return {c, bad ? c : ~c, a, d};
    endfunction : mk
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK(prog_mem_addr_oe, 1'b0)
        `CHK(prog_mem_write, 1'b0)
        `CHK(scratch_write_en_n, 1'b1)
        `CHK(link_ready, 1'b1)
        $display("test reset done");
    endtask : t_reset
    task automatic t_prog();
        pm_seen = '0;
        prog_data_in = 11'h5a6;
        pu_u.frame(mk(PPB_FN_PM_WRITE, 0, 13'h1a5c, 11'h3c3), 0, rep);
        `CHK(pm_seen, 13'h1a5c)
        pu_u.frame(mk(PPB_FN_PM_READ, 0, 13'h0a53, 11'h000), 1, rep);
        `CHK(rep, 11'h5a6)
        $display("test program memory done");
    endtask : t_prog
    task automatic t_scratch();
        sp_seen = '0;
        sp_val = 4'hc;
        pu_u.frame(mk(PPB_FN_SP_WRITE, 0, 13'h0012, 11'h009), 0, rep);
        `CHK(sp_seen, 4'h9)
        pu_u.frame(mk(PPB_FN_SP_READ, 0, 13'h0012, 11'h000), 1, rep);
        `CHK(rep, 11'h00c)
        $display("test scratchpad done");
    endtask : t_scratch
    task automatic t_bad();
        int d0;
        d0 = drv;
        pu_u.frame(mk(PPB_FN_PM_WRITE, 1, 13'h0fff, 11'h7ff), 0, rep);
        `CHK(code_error, 1'b1)
        pu_u.frame(mk(PPB_FN_NOP, 0, 13'h0fff, 11'h7ff), 0, rep);
        `CHK(drv == d0, 1'b1)
        $display("test bad code done");
    endtask : t_bad
    task automatic t_stop();
        pu_u.frame(mk(PPB_FN_STOP, 0, 13'h0000, 11'h000), 0, rep);
        `CHK(stop_request, 1'b1)
        `CHK(system_stop_en_n, 1'b0)
        cpu_stopped = 1'b0;
        repeat (10) @(negedge core_clk);
        `CHK(system_stop_en_n, 1'b1)
        cpu_stopped = 1'b1;
        pu_u.frame(mk(PPB_FN_RUN, 0, 13'h0000, 11'h000), 0, rep);
        `CHK(stop_request, 1'b0)
        $display("test stop and run done");
    endtask : t_stop
    initial begin
        reset_n = 1'b0;
        cpu_stopped = 1'b1;
        prog_data_in = '0;
        instr_in = 5'h00;
        sp_val = 4'h0;
        n_fail = 0;
        n_checks = 0;
        cyc = 0;
        drv = 0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge core_clk);
        t_reset();
        t_prog();
        t_scratch();
        t_bad();
        t_stop();
        results();
    end
endmodule : ppb_bridge_bench

/* File: dv/ppb_link_model.sv */
// Purpose: programming unit model sending frames over the link
// Assumes: link clock 160 ns, stands high between frames
// Notes:   reply bits sampled just before each link clock rise
`timescale 1ns/10ps
module ppb_link_model (
    output logic      link_clock_n,
    output logic      link_data_in_n,
    output logic      transfer_req_n,
    input  wire logic link_data_out,
    input  wire logic link_ready
);
    initial begin
        link_clock_n   = 1'b1;
        link_data_in_n = 1'b0;
        transfer_req_n = 1'b1;
    end
    task automatic tick(input logic b, output logic r);
        link_data_in_n = ~b;
        link_clock_n   = 1'b0;
        #80;
        r = link_data_out;
        link_clock_n = 1'b1;
        #80;
        link_data_in_n = b; // hold over, then show the inverse
    endtask : tick
    task automatic frame(input logic [31:0] f, input bit rd,
                         output logic [10:0] rep);
        logic r;
        int   i;
        rep = '0;
        transfer_req_n = 1'b0;
        #400;
        for (i = 31; i >= 0; i--) tick(f[i], r);
        if (rd) begin
            for (i = 0; i < 250 && link_ready !== 1'b0; i++) #8;
            for (i = 0; i < 2500 && link_ready !== 1'b1; i++) #8;
            for (i = 10; i >= 0; i--) tick(1'b0, rep[i]);
        end else #2000;
        transfer_req_n = 1'b1;
        #400;
    endtask : frame
endmodule : ppb_link_model

/* File: src/ppb_bridge.sv */
// Purpose: programming port to processor bus bridge
// Assumes: link clock sampled by core_clk; processor halts on request
// Notes:   frame = code, ~code, address, data, msb first, on rising
//          link clock; a reply of the program word or scratch nibble follows reads
`timescale 1ns/10ps
// Functional notes
// R1 - address bus driven only when enable low
// R2 - scratch data direction follows write enable
// R3 - processor returns program word on inputs
// R4 - all bus actions timed from processor clock; loss of stop in PPB_DRIVE releases the bus at once
// R5 - stop indication high means processor stopped
// R6 - program write strobe high stores data
// R7 - scratch write enable low stores data
// R8 - active-low link clock times serial transfers
// R9 - separate data lines each direction
// R10 - ready shows availability for transfer
// R11 - programming unit requests transfer active low
// R12 - every action commanded by 4-bit code
// R13 - code sent true and inverted
// R14 - drive bus only after stop seen
// R15 - mismatched code ignored, no bus action
module ppb_bridge
    import ppb_pkg::*;
#(
    parameter int STROBE_CYC = PPB_STROBE_CYC
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   cpu_clock,
    input  wire logic                   cpu_stopped,
    input  wire logic [PPB_PDATA_W-1:0] prog_data_in,
    input  wire logic [4:0]             instr_in,
    output logic [PPB_ADDR_W-1:0]       prog_mem_addr,
    output logic                        prog_mem_addr_oe,
    output logic                        addr_bus_enable_n,
    output logic                        update_phase,
    output logic                        prog_mem_write,
    output logic [PPB_SDATA_W-1:0]      scratch_data_out,
    output logic                        scratch_data_oe,
    input  wire logic [PPB_SDATA_W-1:0] scratch_data_in,
    output logic                        scratch_write_en_n,
    output logic                        stop_request,
    input  wire logic                   link_clock_n,
    input  wire logic                   link_data_in_n,
    output logic                        link_data_out,
    input  wire logic                   transfer_req_n,
    output logic                        link_ready,
    output logic                        system_stop_en_n,
    output logic                        code_error
);
    // strobe counter is eight bits wide and must run at least once
    if (STROBE_CYC < 1 || STROBE_CYC > 255) begin : g_bad_strobe
        $error("STROBE_CYC out of range");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic lclk_s, ldat_s, lreq_s, cclk_s, stop_s;

    ppb_sync #(.RESET_VAL(1'b1)) u_lclk (.core_clk(core_clk),
        .reset_n(reset_n), .async_in(link_clock_n), .sync_out(lclk_s));
    ppb_sync #(.RESET_VAL(1'b1)) u_ldat (.core_clk(core_clk),
        .reset_n(reset_n), .async_in(link_data_in_n), .sync_out(ldat_s));
    ppb_sync #(.RESET_VAL(1'b1)) u_lreq (.core_clk(core_clk),
        .reset_n(reset_n), .async_in(transfer_req_n), .sync_out(lreq_s));
    ppb_sync #(.RESET_VAL(1'b0)) u_cclk (.core_clk(core_clk),
        .reset_n(reset_n), .async_in(cpu_clock), .sync_out(cclk_s));
    ppb_sync #(.RESET_VAL(1'b0)) u_stop (.core_clk(core_clk),
        .reset_n(reset_n), .async_in(cpu_stopped), .sync_out(stop_s));

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic lclk_d_r, cclk_d_r;
    logic lclk_rise, lclk_fall, cclk_rise;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lclk_d_r <= 1'b1;
            cclk_d_r <= 1'b0;
        end else begin
            lclk_d_r <= lclk_s;
            cclk_d_r <= cclk_s;
        end
    end

    // active-low link clock: data sampled as the line returns high
    assign lclk_rise = lclk_s & ~lclk_d_r;                      // R8
    assign lclk_fall = ~lclk_s & lclk_d_r;
    assign cclk_rise = cclk_s & ~cclk_d_r;                      // R4

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    ppb_state_e state_r;
    logic [PPB_FRAME_W-1:0] shift_r;
    logic [5:0]             bit_cnt_r;
    logic [PPB_REPLY_W-1:0] reply_r;
    logic [7:0]             strobe_cnt_r;
    logic [3:0]             code_r;

    function automatic logic code_ok(input logic [PPB_FRAME_W-1:0] f);
        code_ok = (f[PPB_FRAME_W-1 -: 4] == ~f[PPB_FRAME_W-5 -: 4]);
    endfunction : code_ok

    function automatic logic needs_bus(input logic [3:0] c);
        needs_bus = (c == PPB_FN_PM_WRITE) || (c == PPB_FN_PM_READ) ||
                    (c == PPB_FN_SP_WRITE) || (c == PPB_FN_SP_READ);
    endfunction : needs_bus

    wire logic [3:0] rx_code = shift_r[PPB_FRAME_W-1 -: 4];
    wire logic [PPB_ADDR_W-1:0] rx_addr =
        shift_r[PPB_PDATA_W +: PPB_ADDR_W];
    wire logic [PPB_PDATA_W-1:0] rx_data = shift_r[PPB_PDATA_W-1:0];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= PPB_IDLE;
        end else begin
            unique case (state_r)
                PPB_IDLE: begin
                    if (!lreq_s) begin                          // R11
                        state_r <= PPB_RECV;
                    end
                end
                PPB_RECV: begin
                    if (lclk_rise &&
                        bit_cnt_r == 6'(PPB_FRAME_W - 1)) begin
                        state_r <= PPB_CHECK;
                    end else if (lreq_s) begin
                        state_r <= PPB_IDLE;
                    end
                end
                PPB_CHECK: begin
                    if (!code_ok(shift_r)) begin                // R13
                        state_r <= PPB_IDLE;                    // R15
                    end else if (needs_bus(rx_code)) begin      // R12
                        state_r <= PPB_WAIT;
                    end else begin
                        state_r <= PPB_IDLE;
                    end
                end
                PPB_WAIT: begin
                    if (stop_s && cclk_rise) begin              // R14
                        state_r <= PPB_DRIVE;
                    end
                end
                PPB_DRIVE: begin
                    if (strobe_cnt_r == 8'd0 && cclk_rise) begin
                        state_r <= PPB_SEND;
                    end else if (!stop_s) begin
                        state_r <= PPB_IDLE;
                    end
                end
                PPB_SEND: begin
                    if (lreq_s) begin
                        state_r <= PPB_IDLE;
                    end
                end
                // two of the eight codes are unused: recover to idle
                default: begin
                    state_r <= PPB_IDLE;
                end
            endcase
        end
    end

    // serial receive, inverted data line
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_r   <= '0;
            bit_cnt_r <= 6'd0;
        end else if (state_r == PPB_IDLE) begin
            bit_cnt_r <= 6'd0;
        end else if (state_r == PPB_RECV && lclk_rise) begin
            shift_r   <= {shift_r[PPB_FRAME_W-2:0], ~ldat_s};   // R9
            bit_cnt_r <= bit_cnt_r + 6'd1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            code_r     <= PPB_FN_NOP;
            code_error <= 1'b0;
            stop_request <= 1'b0;
        end else if (state_r == PPB_CHECK) begin
            code_error <= ~code_ok(shift_r);                    // R15
            if (code_ok(shift_r)) begin
                code_r <= rx_code;
                if (rx_code == PPB_FN_STOP) begin
                    stop_request <= 1'b1;
                end else if (rx_code == PPB_FN_RUN) begin
                    stop_request <= 1'b0;
                end
            end
        end
    end

    // strobe width counter, counted in processor clock edges
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_cnt_r <= 8'd0;
        end else if (state_r == PPB_WAIT) begin
            strobe_cnt_r <= 8'(STROBE_CYC);
        end else if (state_r == PPB_DRIVE && strobe_cnt_r != 8'd0 &&
                     cclk_rise) begin                           // R4
            strobe_cnt_r <= strobe_cnt_r - 8'd1;
        end
    end

    // ------------------------------------------------------------
    // processor bus drive
    // ------------------------------------------------------------
    logic driving;
    assign driving = (state_r == PPB_DRIVE) && stop_s;          // R14

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_bus_enable_n  <= 1'b1;
            update_phase       <= 1'b0;
            prog_mem_addr      <= '0;
            prog_mem_addr_oe   <= 1'b0;
            prog_mem_write     <= 1'b0;
            scratch_write_en_n <= 1'b1;
            scratch_data_out   <= '0;
            scratch_data_oe    <= 1'b0;
        end else begin
            addr_bus_enable_n <= ~driving;
            update_phase      <= driving;
            prog_mem_addr_oe  <= driving;                       // R1
            prog_mem_addr     <= driving ? rx_addr : '0;        // R1
            prog_mem_write    <= driving &&
                                 code_r == PPB_FN_PM_WRITE;     // R6
            scratch_write_en_n <= ~(driving &&
                                 code_r == PPB_FN_SP_WRITE);    // R7
            // data lane only driven while the write enable is low
            scratch_data_oe   <= driving &&
                                 code_r == PPB_FN_SP_WRITE;     // R2
            scratch_data_out  <= rx_data[PPB_SDATA_W-1:0];
        end
    end

    // capture read data at end of bus cycle, then shift it back
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reply_r       <= '0;
            link_data_out <= 1'b0;
        end else if (state_r == PPB_DRIVE && strobe_cnt_r == 8'd0 &&
                     cclk_rise) begin
            reply_r <= (code_r == PPB_FN_SP_READ) ?
                {{(PPB_REPLY_W-PPB_SDATA_W){1'b0}}, scratch_data_in}
                : prog_data_in;                                 // R3
        end else if (state_r == PPB_SEND && lclk_fall) begin
            link_data_out <= reply_r[PPB_REPLY_W-1];            // R9
            reply_r       <= {reply_r[PPB_REPLY_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // link status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_ready       <= 1'b0;
            system_stop_en_n <= 1'b1;
        end else begin
            link_ready <= (state_r == PPB_IDLE) ||
                          (state_r == PPB_RECV) ||
                          (state_r == PPB_SEND);                // R10
            system_stop_en_n <= ~(stop_request & stop_s);       // R5
        end
    end

    // instruction bits kept for future decode
    logic unused_ok;
    assign unused_ok = ^instr_in;
endmodule : ppb_bridge

/* File: src/ppb_pkg.sv */
// Purpose: shared constants for the programming port bus access block
// Assumes: core_clk at 125 MHz, link clock far slower
// Notes:   frame layout is fixed: code, inverted code, address, data
package ppb_pkg;
    localparam int PPB_CODE_W   = 4;
    localparam int PPB_ADDR_W   = 13;
    localparam int PPB_PDATA_W  = 11;
    localparam int PPB_SDATA_W  = 4;
    localparam int PPB_FRAME_W  = 2 * PPB_CODE_W + PPB_ADDR_W + PPB_PDATA_W;
    localparam int PPB_REPLY_W  = PPB_PDATA_W;
    localparam int PPB_CLK_NS   = 8;
    localparam int PPB_STROBE_NS = 200;
    localparam int PPB_STROBE_CYC = (PPB_STROBE_NS + PPB_CLK_NS - 1)
                                    / PPB_CLK_NS;
    // function mode codes
    localparam logic [3:0] PPB_FN_NOP       = 4'h0;
    localparam logic [3:0] PPB_FN_PM_WRITE  = 4'h1;
    localparam logic [3:0] PPB_FN_PM_READ   = 4'h2;
    localparam logic [3:0] PPB_FN_SP_WRITE  = 4'h3;
    localparam logic [3:0] PPB_FN_SP_READ   = 4'h4;
    localparam logic [3:0] PPB_FN_STOP      = 4'h5;
    localparam logic [3:0] PPB_FN_RUN       = 4'h6;

    typedef enum logic [2:0] {
        PPB_IDLE  = 3'b000,
        PPB_RECV  = 3'b001,
        PPB_CHECK = 3'b011,
        PPB_WAIT  = 3'b010,
        PPB_DRIVE = 3'b110,
        PPB_SEND  = 3'b111
    } ppb_state_e;
endpackage : ppb_pkg

/* File: src/ppb_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous input levels
// Notes:   output changes once stages two and three agree
`timescale 1ns/10ps
module ppb_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [2:0] stage_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_r <= {3{RESET_VAL}};
        end else begin
            stage_r <= {stage_r[1:0], async_in};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_out <= RESET_VAL;
        end else if (stage_r[1] == stage_r[2]) begin
            sync_out <= stage_r[2];
        end
    end
endmodule : ppb_sync
